// file: sdlmc_defines.svh
// Constants for the serial converter load and mode control block.
`ifndef SDLMC_DEFINES_SVH
`define SDLMC_DEFINES_SVH
`define SDLMC_WORD_BITS 16
`define SDLMC_CNT_W 5
`define SDLMC_LAST_EDGE 5'h10
`define SDLMC_MODE_HI 13
`define SDLMC_MODE_LO 12
`define SDLMC_CODE_HI 11
`define SDLMC_CODE_LO 4
`define SDLMC_CODE_RESET 8'h00
`define SDLMC_MODE_RESET 2'h0
`define SDLMC_CLK_MHZ 100
`define SDLMC_WAKE_NS 2500
`define SDLMC_WAKE_CYC ((`SDLMC_WAKE_NS * `SDLMC_CLK_MHZ + 999) / 1000)
`define SDLMC_WAKE_W 9
`endif

// file: sdlmc_pkg.sv
// Types for the serial converter load and mode control block.
package sdlmc_pkg;
  typedef enum logic [1:0] {
    SDLMC_NORMAL,
    SDLMC_PD_1K,
    SDLMC_PD_100K,
    SDLMC_PD_TRI
  } sdlmc_mode_t;
endpackage

// file: sdlmc_sync.sv
// Three-stage input synchroniser with agreement-based change detection.
module sdlmc_sync (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic async_in,
  input wire logic reset_val,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_q, s2_q, s3_q, lv_q;
  logic s1_d, s2_d, s3_d, lv_d;
  always_comb
  begin
    s1_d = async_in;
    s2_d = s1_q;
    s3_d = s2_q;
    lv_d = (s2_q == s3_q) ? s3_q : lv_q;
  end
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      s1_q <= reset_val;
      s2_q <= reset_val;
      s3_q <= reset_val;
      lv_q <= reset_val;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      lv_q <= lv_d;
    end
  end
  assign level = lv_q;
  assign rise = lv_d & ~lv_q;
  assign fall = ~lv_d & lv_q;
endmodule

// file: sdlmc_top.sv
// Serial frame capture, code register and power mode control.
//
// Functional notes
// RULE1 - A frame opens only on a high-to-low transition of frame select.
// RULE2 - Each falling serial clock edge in a frame shifts one data bit in.
// RULE3 - The sixteenth falling edge captures the last bit and executes the word.
// RULE4 - Host keeps frame select low through at least sixteen falling edges.
// RULE5 - After the word, select may stay low; new frame needs high then fall.
// RULE6 - Host may park frame select low between frames to save power.
// RULE7 - Word order: two ignored, two mode, eight code, four ignored bits.
// RULE8 - Code bits load into the code register on the sixteenth edge.
// RULE9 - Select rising early clears the shift state; nothing changes.
// RULE10 - Reset loads code zero, held until the first complete frame.
// RULE11 - Mode comes from word bits 13 and 12 of each valid frame.
// RULE12 - Modes: normal, 1k to ground, 100k to ground, three-state.
// RULE13 - Mode zero drives the output from the code register.
// RULE14 - Power-down modes disconnect amplifier, apply termination, shut down; three-state mode raises neither term_1k nor term_100k.
// RULE15 - Power-down leaves the code register unchanged; the code loads the code bits of power-down words too.
// RULE16 - Output valid is flagged a recovery time after leaving power-down.
// RULE17 - Code is straight binary; output equals supply times code over 256.
// RULE18 - Host keeps the serial clock at or below 30 MHz.
// RULE19 - Host drives data valid on the falling clock edge.
// RULE20 - Byte hosts keep select low across two bytes.
// RULE21 - Host sends the most significant bit first.
// RULE22 - With select high, clock edges are ignored entirely.
`include "sdlmc_defines.svh"
module sdlmc_top (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic frame_sel_n,
  input wire logic ser_clk,
  input wire logic ser_din,
  output logic [7:0] dac_code,
  output sdlmc_pkg::sdlmc_mode_t dac_mode,
  output logic amp_enable,
  output logic term_1k,
  output logic term_100k,
  output logic out_valid,
  output logic word_done
);
  import sdlmc_pkg::*;

  logic sel_lvl, sel_rise, sel_fall;
  logic sck_fall;
  logic din_lvl;

  sdlmc_sync u_sel (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(frame_sel_n),
    .reset_val(1'b1),
    .level(sel_lvl),
    .rise(sel_rise),
    .fall(sel_fall)
  );

  sdlmc_sync u_sck (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(ser_clk),
    .reset_val(1'b0),
    .level(),
    .rise(),
    .fall(sck_fall)
  );

  // Data takes the same three-stage path so it stays aligned with the clock edge.
  sdlmc_sync u_din (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(ser_din),
    .reset_val(1'b0),
    .level(din_lvl),
    .rise(),
    .fall()
  );

  logic active_q, active_d;
  logic [`SDLMC_WORD_BITS-1:0] shift_q, shift_d;
  logic [`SDLMC_CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0] code_q, code_d;
  sdlmc_mode_t mode_q, mode_d;
  logic done_q, done_d;
  logic [`SDLMC_WAKE_W-1:0] wake_q, wake_d;
  logic valid_q, valid_d;
  logic [`SDLMC_WORD_BITS-1:0] word_next;
  logic exec;

  function automatic logic [7:0] word_code(input logic [`SDLMC_WORD_BITS-1:0] w);
    word_code = w[`SDLMC_CODE_HI:`SDLMC_CODE_LO]; // [RULE7]
  endfunction

  function automatic sdlmc_mode_t word_mode(input logic [`SDLMC_WORD_BITS-1:0] w);
    word_mode = sdlmc_mode_t'(w[`SDLMC_MODE_HI:`SDLMC_MODE_LO]); // [RULE11]
  endfunction

  always_comb
  begin
    active_d = active_q;
    shift_d = shift_q;
    cnt_d = cnt_q;
    code_d = code_q;
    mode_d = mode_q;
    done_d = 1'b0;
    word_next = {shift_q[`SDLMC_WORD_BITS-2:0], din_lvl};
    exec = 1'b0;
    if (sel_rise)
    begin
      // An early rise abandons the partial word; a finished one is already applied.
      active_d = 1'b0; // [RULE9]
      shift_d = '0; // [RULE9]
      cnt_d = '0;
    end
    else if (sel_fall)
    begin
      active_d = 1'b1; // [RULE1]
      shift_d = '0;
      cnt_d = '0;
    end
    else if (active_q && !sel_lvl && sck_fall && cnt_q != `SDLMC_LAST_EDGE) // [RULE22]
    begin
      shift_d = word_next; // [RULE2]
      cnt_d = cnt_q + 1'b1;
      if (cnt_q == `SDLMC_LAST_EDGE - 1'b1)
      begin
        exec = 1'b1; // [RULE3]
        done_d = 1'b1;
        active_d = 1'b0; // [RULE5]
        code_d = word_code(word_next); // [RULE8]
        mode_d = word_mode(word_next); // [RULE12]
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      active_q <= 1'b0;
      shift_q <= '0;
      cnt_q <= '0;
      code_q <= `SDLMC_CODE_RESET; // [RULE10]
      mode_q <= SDLMC_NORMAL;
      done_q <= 1'b0;
    end
    else
    begin
      active_q <= active_d;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      code_q <= code_d;
      mode_q <= mode_d;
      done_q <= done_d;
    end
  end

  // Recovery timer restarts whenever a power-down mode is left for normal.
  always_comb
  begin
    wake_d = wake_q;
    valid_d = valid_q;
    if (exec && mode_d != SDLMC_NORMAL)
    begin
      valid_d = 1'b0;
      wake_d = '0;
    end
    else if (exec && mode_q != SDLMC_NORMAL)
    begin
      valid_d = 1'b0; // [RULE16]
      wake_d = `SDLMC_WAKE_W'(`SDLMC_WAKE_CYC);
    end
    else if (wake_q != '0)
    begin
      wake_d = wake_q - 1'b1;
      valid_d = (wake_q == `SDLMC_WAKE_W'(1)); // [RULE16]
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      wake_q <= '0;
      valid_q <= 1'b1;
    end
    else
    begin
      wake_q <= wake_d;
      valid_q <= valid_d;
    end
  end

  assign dac_code = code_q; // [RULE15] [RULE17]
  assign dac_mode = mode_q;
  assign amp_enable = (mode_q == SDLMC_NORMAL); // [RULE13] [RULE14]
  assign term_1k = (mode_q == SDLMC_PD_1K); // [RULE14]
  assign term_100k = (mode_q == SDLMC_PD_100K); // [RULE14]
  assign out_valid = valid_q;
  assign word_done = done_q;

  sequence s_early_abort;
    active_q ##0 sel_rise;
  endsequence

  property p_abort_keeps;
    @(posedge clock) disable iff (!reset_n)
    s_early_abort |=> $stable(code_q) && $stable(mode_q) && shift_q == '0 && !active_q;
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed state"); // [RULE9]

  property p_last_edge_loads;
    @(posedge clock) disable iff (!reset_n)
    exec |=> code_q == $past(word_next[`SDLMC_CODE_HI:`SDLMC_CODE_LO]) && word_done;
  endproperty
  a_last_edge_loads: assert property (p_last_edge_loads) else $error("code not loaded"); // [RULE8]

  property p_mode_load;
    @(posedge clock) disable iff (!reset_n)
    exec |=> mode_q == sdlmc_mode_t'($past(word_next[`SDLMC_MODE_HI:`SDLMC_MODE_LO]));
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode not loaded"); // [RULE11]

  property p_code_only_on_exec;
    @(posedge clock) disable iff (!reset_n)
    !exec |=> $stable(code_q) && $stable(mode_q);
  endproperty
  a_code_only_on_exec: assert property (p_code_only_on_exec) else $error("stray load"); // [RULE15]

  property p_idle_ignored;
    @(posedge clock) disable iff (!reset_n)
    (sel_lvl && !sel_fall) |=> $stable(cnt_q) || cnt_q == '0;
  endproperty
  a_idle_ignored: assert property (p_idle_ignored) else $error("shift while idle"); // [RULE22]

  property p_frame_open;
    @(posedge clock) disable iff (!reset_n)
    sel_fall |=> active_q && cnt_q == '0;
  endproperty
  a_frame_open: assert property (p_frame_open) else $error("frame not opened"); // [RULE1]

  property p_shift_in;
    @(posedge clock) disable iff (!reset_n)
    (active_q && !sel_lvl && !sel_rise && !sel_fall && sck_fall && cnt_q < `SDLMC_LAST_EDGE - 1'b1)
      |=> shift_q[0] == $past(din_lvl) && cnt_q == $past(cnt_q) + 1'b1;
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bit not shifted"); // [RULE2]

  property p_mode_outputs;
    @(posedge clock) disable iff (!reset_n)
    amp_enable == (mode_q == SDLMC_NORMAL) && !(term_1k && term_100k) && !(amp_enable && term_1k);
  endproperty
  a_mode_outputs: assert property (p_mode_outputs) else $error("bad termination"); // [RULE14]

  // A power-down word inside the recovery window keeps the output invalid, which is legal.
  property p_wake_delay;
    @(posedge clock) disable iff (!reset_n)
    (exec && mode_q != SDLMC_NORMAL && mode_d == SDLMC_NORMAL)
      |=> !out_valid ##[249:251] (out_valid || !amp_enable);
  endproperty
  a_wake_delay: assert property (p_wake_delay) else $error("recovery timing wrong"); // [RULE16]

  sequence s_last_edge;
    active_q && !sel_lvl && !sel_rise && !sel_fall && sck_fall
      && cnt_q == `SDLMC_LAST_EDGE - 1'b1;
  endsequence

  sequence s_word_closed;
    word_done && !active_q && cnt_q == `SDLMC_LAST_EDGE;
  endsequence

  property p_last_edge_exec;
    @(posedge clock) disable iff (!reset_n)
    s_last_edge |-> exec ##1 s_word_closed;
  endproperty
  a_last_edge_exec: assert property (p_last_edge_exec) else $error("word not executed"); // [RULE3]

  property p_exec_in_frame;
    @(posedge clock) disable iff (!reset_n)
    exec |-> active_q && !sel_lvl && sck_fall;
  endproperty
  a_exec_in_frame: assert property (p_exec_in_frame) else $error("stray word"); // [RULE22]

  property p_done_pulse;
    @(posedge clock) disable iff (!reset_n)
    word_done |=> !word_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long"); // [RULE3]

  // Once a word has run, extra clock edges must not disturb the shift state.
  property p_closed_holds_word;
    @(posedge clock) disable iff (!reset_n)
    !active_q |=> $stable(shift_q) || shift_q == '0;
  endproperty
  a_closed_holds_word: assert property (p_closed_holds_word) else $error("shift after close"); // [RULE5]

  property p_recovery_low;
    @(posedge clock) disable iff (!reset_n)
    wake_q != '0 |-> !out_valid;
  endproperty
  a_recovery_low: assert property (p_recovery_low) else $error("valid during recovery"); // [RULE16]

  property p_pd_drops_valid;
    @(posedge clock) disable iff (!reset_n)
    (exec && mode_d != SDLMC_NORMAL) |=> !out_valid;
  endproperty
  a_pd_drops_valid: assert property (p_pd_drops_valid) else $error("valid in power-down"); // [RULE14]

  property p_valid_steady;
    @(posedge clock) disable iff (!reset_n)
    (!exec && wake_q == '0) |=> $stable(out_valid);
  endproperty
  a_valid_steady: assert property (p_valid_steady) else $error("valid moved"); // [RULE16]
endmodule

// file: sdlmc_host_model.sv
// Host model that drives the three-wire serial write link.
module sdlmc_host_model (
  input wire logic clock,
  output logic frame_sel_n,
  output logic ser_clk,
  output logic ser_din
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    frame_sel_n = 1'b1;
    ser_clk = 1'b0;
    ser_din = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One 125 ns link period, well below the top link rate.
  // The link is asynchronous to the system clock, so its falling edges sit off the clock grid.
  task automatic bit_out(input logic b);
    ser_clk <= 1'b1;
    ser_din <= b; // Data is stable at the falling edge.
    #62.5;
    ser_clk <= 1'b0;
    #62.5;
  endtask
  // Select is high for a gap, then falls to open the frame.
  task automatic send(input logic [15:0] w, input int nbits, input int split, input bit park);
    int i;
    frame_sel_n <= 1'b1;
    idle(8);
    frame_sel_n <= 1'b0;
    idle(6);
    for (i = 0; i < nbits; i++)
    begin
      if (i == 8) idle(split); // Byte host pause with select still low.
      bit_out(w[4'hf - i[3:0]]); // Most significant bit first.
    end
    ser_din <= ~ser_din;
    idle(6);
    if (!park) frame_sel_n <= 1'b1; // Parking low saves power.
  endtask
  // Deliberate clock edges while select is high.
  task automatic stray(input int n);
    int i;
    frame_sel_n <= 1'b1;
    idle(8);
    for (i = 0; i < n; i++)
      bit_out(i[0]);
  endtask
endmodule

// file: tb_serial_dac_load_and_mode_control.sv
// Self-checking bench for the serial converter load and mode control block.
module tb_serial_dac_load_and_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  import sdlmc_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic frame_sel_n, ser_clk, ser_din;
  logic [7:0] dac_code;
  sdlmc_mode_t dac_mode;
  logic amp_enable, term_1k, term_100k, out_valid, word_done;
  int n_errors = 0;
  int comparisons = 0;
  int n_done = 0;
  int cyc = 0;
  int t_done = 0;
  logic [7:0] e_code = 8'h00;
  logic [1:0] e_mode = 2'h0;
  logic [15:0] w;
  int k, d;
  initial
  begin
    forever #5 clock = ~clock;
  end
  sdlmc_host_model host (.clock(clock), .frame_sel_n(frame_sel_n), .ser_clk(ser_clk),
    .ser_din(ser_din));
  sdlmc_top dut (.clock(clock), .reset_n(reset_n), .frame_sel_n(frame_sel_n),
    .ser_clk(ser_clk), .ser_din(ser_din), .dac_code(dac_code), .dac_mode(dac_mode),
    .amp_enable(amp_enable), .term_1k(term_1k), .term_100k(term_100k),
    .out_valid(out_valid), .word_done(word_done));
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (word_done === 1'b1)
    begin
      n_done <= n_done + 1;
      t_done <= cyc;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    comparisons++;
    if (seen !== expv)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  function automatic logic [2:0] drive_of(input logic [1:0] m);
    return {m == 2'h0, m == 2'h1, m == 2'h2};
  endfunction
  task automatic outs();
    check(dac_code, e_code);
    check(dac_mode, e_mode);
    check({amp_enable, term_1k, term_100k}, drive_of(e_mode));
  endtask
  task automatic wr(input logic [15:0] wd, input int nbits, input int split, input bit park);
    int n0;
    n0 = n_done;
    host.send(wd, nbits, split, park);
    host.idle(10);
    if (nbits >= 16)
    begin
      e_code = wd[11:4];
      e_mode = wd[13:12];
    end
    check(16'(n_done - n0), 16'(nbits >= 16));
    outs();
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'hbe84));
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    host.idle(4);
    outs();
    check(out_valid, 1'b1);
    $display("test reset done");
    // Power-down words repeat the held code so the register must stay put.
    for (k = 0; k < 12; k++)
    begin
      w = 16'($urandom);
      if (k < 4) w[13:12] = 2'(k);
      if (w[13:12] != 2'h0) w[11:4] = e_code;
      wr(w, 16, (k % 3) * 20, k[0]);
    end
    $display("test random words done");
    wr({2'h0, ~e_mode, ~e_code, 4'h0}, 15, 0, 1'b0);
    $display("test abort done");
    d = n_done;
    host.stray(16);
    host.idle(10);
    check(16'(n_done - d), 16'h0);
    outs();
    wr({2'h3, 2'h0, 8'h81, 4'hf}, 24, 0, 1'b1);
    wr({2'h0, 2'h0, 8'h00, 4'h0}, 16, 0, 1'b0);
    $display("test extra edges and park done");
    wr({2'h0, 2'h2, e_code, 4'h0}, 16, 0, 1'b0);
    check(out_valid, 1'b0);
    wr({2'h0, 2'h0, 8'hff, 4'h0}, 16, 0, 1'b0);
    check(out_valid, 1'b0);
    for (k = 0; k < 400 && out_valid !== 1'b1; k++)
      @(posedge clock);
    if (k == 400)
    begin
      n_errors++;
      wrap_up();
    end
    check(16'((cyc - t_done) inside {[248:252]}), 16'h1);
    $display("test recovery done");
    // A reset in mid-run must bring a non-zero code back to zero.
    reset_n <= 1'b0;
    host.idle(4);
    reset_n <= 1'b1;
    host.idle(4);
    e_code = 8'h00;
    e_mode = 2'h0;
    outs();
    check(out_valid, 1'b1);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule
